//--- rtl/acis_pkg.sv
package acis_pkg;

    // ****************************************************************
    // Processor port dimensions.
    // ****************************************************************
    localparam int ACIS_ADDR_W = 8;
    localparam int ACIS_DATA_W = 8;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] ACIS_OFS_PORT_SUMMARY = 8'h00;
    localparam logic [7:0] ACIS_OFS_TX_IRQ_EN = 8'h28;
    localparam logic [7:0] ACIS_OFS_RX_IRQ_EN = 8'h29;
    localparam logic [7:0] ACIS_OFS_TX_FLAGS = 8'h2c;
    localparam logic [7:0] ACIS_OFS_RX_FLAGS = 8'h2d;
    localparam logic [7:0] ACIS_OFS_TX_STATUS = 8'h2e;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [7:0] ACIS_RST_TX_IRQ_EN = 8'hfc;
    localparam logic [7:0] ACIS_RST_RX_IRQ_EN = 8'hff;
    localparam logic [7:0] ACIS_RST_TX_STATUS = 8'h00;
    localparam logic [7:0] ACIS_RST_FLAGS = 8'h00;

    // ****************************************************************
    // Implemented bit masks of the flag and status registers, and the dual-edge event bits.
    // ****************************************************************
    localparam logic [7:0] ACIS_MASK_TX_FLAGS = 8'hfc;
    localparam logic [7:0] ACIS_MASK_RX_FLAGS = 8'hef;
    localparam logic [7:0] ACIS_MASK_TX_EVENTS = 8'hfc;
    localparam logic [7:0] ACIS_MASK_TX_STATUS = 8'hfd;
    localparam logic [7:0] ACIS_DUAL_RX = 8'h80;
    localparam logic [7:0] ACIS_DUAL_TX = 8'h00;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int ACIS_BIT_PARITY_ERR = 7;
    localparam int ACIS_BIT_CELL_START_ERR = 6;
    localparam int ACIS_BIT_TX_OVERFLOW = 5;
    localparam int ACIS_BIT_RX_OVERFLOW = 4;
    localparam int ACIS_BIT_CELL_SENT = 3;
    localparam int ACIS_BIT_BUS_CONFLICT = 2;
    localparam int ACIS_BIT_REPEAT_LAST = 0;
    localparam int ACIS_BIT_DELIN_LOSS = 7;
    localparam int ACIS_BIT_HEC_DETECT = 6;
    localparam int ACIS_BIT_HEC_CORRECT = 5;
    localparam int ACIS_BIT_RECEIVER_HOLD = 4;
    localparam int ACIS_BIT_CELL_RX = 3;
    localparam int ACIS_BIT_IDLE_RX = 2;
    localparam int ACIS_BIT_UNMATCHED = 1;
    localparam int ACIS_BIT_NONZERO_GFC = 0;
    localparam int ACIS_BIT_SUM_TX = 1;
    localparam int ACIS_BIT_SUM_RX = 0;

endpackage : acis_pkg

//--- rtl/acis_event_latch.sv
module acis_event_latch #(
    parameter int W = 8,
    parameter logic [W-1:0] DUAL = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Status levels, enables and clearing read.
    input wire logic [W-1:0] status_in,
    input wire logic [W-1:0] enable_in,
    input wire logic clear_in,
    // Latched flags.
    output logic [W-1:0] flags_out
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] flags;
    } acis_latch_type;

    acis_latch_type st_ff;
    acis_latch_type nxt_st;

    // Edge detection: rising edges always, falling edges only on
    // dual-event bits; an edge latches only while its enable is set,
    // and a new edge wins over a clearing read in the same cycle.
    always_comb begin
        logic [W-1:0] edges;
        edges = '0;
        nxt_st = st_ff;
        edges = (status_in & ~st_ff.prev) | (~status_in & st_ff.prev & DUAL);
        nxt_st.prev = status_in;
        nxt_st.flags = (clear_in ? '0 : st_ff.flags) | (edges & enable_in);
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags_out = st_ff.flags;

endmodule : acis_event_latch

//--- rtl/acis_cell_irq.sv
// Functional notes
// [R1] Receive enable register: one enable per receive event, bits 7..0.
// [R2] Any enabled pending receive flag drives the port delineator interrupt.
// [R3] Receive enable register resets to all ones.
// [R4] Transmit flag bits: 7 parity .. 2 bus conflict; 1 and 0 unused.
// [R5] Single-event flags set on rising status edge only when enabled.
// [R6] Delineation loss flag sets on either edge when enabled.
// [R7] Reading a flag register returns the flags then clears them.
// [R8] Receive flag bits: 7 loss, 6,5 HEC, 3..0 cell types; 4 empty.
// [R9] Transmit status records a start-of-cell error on boundary mismatch.
// [R10] Transmit status records transmit FIFO overflow.
// [R11] Transmit status records receive FIFO overflow.
// [R12] Transmit status flags a bus conflict on duplicate address.
// [R13] Status bit 0 selects repeating last cell, else idle cells.
// [R14] Status event bits hold events since last read; read clears.
// [R15] Masked events are not latched in flag registers.
// [R16] Summary register shows transmit and receive pending flags.
// [R17] Unused bits read zero and ignore writes.
// [R18] An event in the clearing read cycle stays latched.
module acis_cell_irq
    import acis_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Processor register port.
    input wire logic CPU_SEL,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire logic [acis_pkg::ACIS_ADDR_W-1:0] CPU_ADDR,
    input wire logic [acis_pkg::ACIS_DATA_W-1:0] CPU_WDATA,
    output logic [acis_pkg::ACIS_DATA_W-1:0] CPU_RDATA,
    // Transmit events from the cell transmitter and UTOPIA logic.
    input wire logic TX_PARITY_ERR,
    input wire logic TX_FIFO_OVERFLOW,
    input wire logic RX_FIFO_OVERFLOW,
    input wire logic TX_CELL_SENT,
    input wire logic TX_BUS_CONFLICT,
    input wire logic TX_OCTET_STROBE,
    input wire logic TX_CELL_BOUNDARY,
    // Transmit start-of-cell pin.
    input wire logic TX_CELL_START_IN,
    // Receive status from the cell delineator.
    input wire logic RX_DELINEATION_LOSS,
    input wire logic RX_HEC_DETECT,
    input wire logic RX_HEC_CORRECT,
    input wire logic RX_CELL_RX,
    input wire logic RX_IDLE_RX,
    input wire logic RX_UNMATCHED_CELL,
    input wire logic RX_NONZERO_FLOW_CTL,
    // Interrupt, summary and gap-fill control outputs.
    output logic DELINEATOR_PORT_IRQ,
    output logic PORT_SUMMARY_TX,
    output logic PORT_SUMMARY_RX,
    output logic REPEAT_LAST_CELL
);

    // ****************************************************************
    // State of the block.
    // ****************************************************************
    typedef struct packed {
        logic [7:0] tx_en;
        logic [7:0] rx_en;
        logic [7:0] tx_status;
        logic [7:0] rdata;
        logic irq;
        logic sum_tx;
        logic sum_rx;
        logic soc_meta;
        logic soc_sync;
        logic strobe_d1;
        logic strobe_d2;
        logic bound_d1;
        logic bound_d2;
    } acis_state_type;

    acis_state_type st_ff;
    acis_state_type nxt_st;

    // ****************************************************************
    // Access decode.
    // ****************************************************************
    logic rd_access;
    logic wr_access;
    logic rd_tx_flags;
    logic rd_rx_flags;
    logic rd_tx_status;
    logic soc_error;
    logic [7:0] tx_events;
    logic [7:0] rx_levels;
    logic [7:0] tx_flags_raw;
    logic [7:0] rx_flags_raw;
    logic [7:0] tx_flags;
    logic [7:0] rx_flags;

    // Reads and writes are one-cycle strobes qualified by select.
    assign rd_access = CPU_SEL & CPU_RD;
    assign wr_access = CPU_SEL & CPU_WR;
    assign rd_tx_flags = rd_access && (CPU_ADDR == ACIS_OFS_TX_FLAGS);
    assign rd_rx_flags = rd_access && (CPU_ADDR == ACIS_OFS_RX_FLAGS);
    assign rd_tx_status = rd_access && (CPU_ADDR == ACIS_OFS_TX_STATUS);

    // ****************************************************************
    // Transmit event sources.
    // ****************************************************************

    // A start-of-cell mark off a boundary, or a boundary without the
    // mark, is an error; strobe and boundary are delayed to match the
    // two-stage pin synchroniser.
    assign soc_error = st_ff.strobe_d2 &&
        (st_ff.soc_sync != st_ff.bound_d2); // R9

    // Events that load the transmit status register this cycle.
    always_comb begin
        tx_events = 8'h00;
        tx_events[ACIS_BIT_PARITY_ERR] = TX_PARITY_ERR;
        tx_events[ACIS_BIT_CELL_START_ERR] = soc_error; // R9
        tx_events[ACIS_BIT_TX_OVERFLOW] = TX_FIFO_OVERFLOW; // R10
        tx_events[ACIS_BIT_RX_OVERFLOW] = RX_FIFO_OVERFLOW; // R11
        tx_events[ACIS_BIT_CELL_SENT] = TX_CELL_SENT;
        tx_events[ACIS_BIT_BUS_CONFLICT] = TX_BUS_CONFLICT; // R12
    end

    // Receive status levels watched for transitions.
    always_comb begin
        rx_levels = 8'h00;
        rx_levels[ACIS_BIT_DELIN_LOSS] = RX_DELINEATION_LOSS;
        rx_levels[ACIS_BIT_HEC_DETECT] = RX_HEC_DETECT;
        rx_levels[ACIS_BIT_HEC_CORRECT] = RX_HEC_CORRECT;
        rx_levels[ACIS_BIT_CELL_RX] = RX_CELL_RX;
        rx_levels[ACIS_BIT_IDLE_RX] = RX_IDLE_RX;
        rx_levels[ACIS_BIT_UNMATCHED] = RX_UNMATCHED_CELL;
        rx_levels[ACIS_BIT_NONZERO_GFC] = RX_NONZERO_FLOW_CTL;
    end

    // ****************************************************************
    // Interrupt flag latches.
    // ****************************************************************

    // Transmit flags follow rising edges of the sticky status bits.
    acis_event_latch #(
        .W(8),
        .DUAL(ACIS_DUAL_TX)
    ) u_tx_latch (
        .clk(CLK),
        .rst(RST),
        .status_in(st_ff.tx_status & ACIS_MASK_TX_EVENTS), // R5
        .enable_in(st_ff.tx_en), // R15
        .clear_in(rd_tx_flags), // R7
        .flags_out(tx_flags_raw)
    );

    // Receive flags; loss of delineation reacts to both edges.
    acis_event_latch #(
        .W(8),
        .DUAL(ACIS_DUAL_RX) // R6
    ) u_rx_latch (
        .clk(CLK),
        .rst(RST),
        .status_in(rx_levels), // R5
        .enable_in(st_ff.rx_en), // R15
        .clear_in(rd_rx_flags), // R7
        .flags_out(rx_flags_raw)
    );

    // Empty positions are forced low whatever the latch holds.
    assign tx_flags = tx_flags_raw & ACIS_MASK_TX_FLAGS; // R4
    assign rx_flags = rx_flags_raw & ACIS_MASK_RX_FLAGS; // R8

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;

        // Pin synchroniser and matching delay of the octet timing.
        nxt_st.soc_meta = TX_CELL_START_IN;
        nxt_st.soc_sync = st_ff.soc_meta;
        nxt_st.strobe_d1 = TX_OCTET_STROBE;
        nxt_st.strobe_d2 = st_ff.strobe_d1;
        nxt_st.bound_d1 = TX_CELL_BOUNDARY;
        nxt_st.bound_d2 = st_ff.bound_d1;

        // Sticky transmit events; a read clears them, a new event in
        // the same cycle survives the clear.
        nxt_st.tx_status[7:2] = (rd_tx_status ?
            6'h00 : st_ff.tx_status[7:2]) | tx_events[7:2]; // R14 R18
        nxt_st.tx_status[1] = 1'b0; // R17

        // Register writes; read-only registers ignore writes.
        if (wr_access) begin
            unique case (CPU_ADDR)
                ACIS_OFS_TX_IRQ_EN: begin
                    nxt_st.tx_en = CPU_WDATA & ACIS_MASK_TX_FLAGS;
                end
                ACIS_OFS_RX_IRQ_EN: begin
                    nxt_st.rx_en = CPU_WDATA; // R1
                end
                ACIS_OFS_TX_STATUS: begin
                    nxt_st.tx_status[ACIS_BIT_REPEAT_LAST] =
                        CPU_WDATA[ACIS_BIT_REPEAT_LAST]; // R13
                end
                default: begin
                    nxt_st.rdata = st_ff.rdata; // R17
                end
            endcase
        end

        // Read data is captured before the clearing edge takes effect.
        if (rd_access) begin
            unique case (CPU_ADDR)
                ACIS_OFS_PORT_SUMMARY: begin
                    nxt_st.rdata = 8'h00;
                    nxt_st.rdata[ACIS_BIT_SUM_TX] = st_ff.sum_tx;
                    nxt_st.rdata[ACIS_BIT_SUM_RX] = st_ff.sum_rx;
                end
                ACIS_OFS_TX_IRQ_EN: begin
                    nxt_st.rdata = st_ff.tx_en;
                end
                ACIS_OFS_RX_IRQ_EN: begin
                    nxt_st.rdata = st_ff.rx_en;
                end
                ACIS_OFS_TX_FLAGS: begin
                    nxt_st.rdata = tx_flags; // R7
                end
                ACIS_OFS_RX_FLAGS: begin
                    nxt_st.rdata = rx_flags; // R7
                end
                ACIS_OFS_TX_STATUS: begin
                    nxt_st.rdata = st_ff.tx_status & ACIS_MASK_TX_STATUS;
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        // Summary bits stand while any flag of their register pends.
        nxt_st.sum_tx = |tx_flags; // R16
        nxt_st.sum_rx = |rx_flags; // R16

        // Enabled pending flags raise the port delineator interrupt.
        nxt_st.irq = |(tx_flags & st_ff.tx_en) |
            |(rx_flags & st_ff.rx_en); // R2
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_ff <= '0;
            st_ff.tx_en <= ACIS_RST_TX_IRQ_EN;
            st_ff.rx_en <= ACIS_RST_RX_IRQ_EN; // R3
            st_ff.tx_status <= ACIS_RST_TX_STATUS; // R13
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign CPU_RDATA = st_ff.rdata;
    assign DELINEATOR_PORT_IRQ = st_ff.irq; // R2
    assign PORT_SUMMARY_TX = st_ff.sum_tx;
    assign PORT_SUMMARY_RX = st_ff.sum_rx;
    assign REPEAT_LAST_CELL = st_ff.tx_status[ACIS_BIT_REPEAT_LAST]; // R13

endmodule : acis_cell_irq

//--- verif/acis_cell_irq_monitor.sv
module acis_cell_irq_monitor
    import acis_pkg::*;
(
    // Clock, reset and register port.
    input wire logic CLK,
    input wire logic RST,
    input wire logic CPU_SEL,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire logic [acis_pkg::ACIS_ADDR_W-1:0] CPU_ADDR,
    input wire logic [acis_pkg::ACIS_DATA_W-1:0] CPU_WDATA,
    input wire logic [acis_pkg::ACIS_DATA_W-1:0] CPU_RDATA,
    // Interrupt, summary and gap-fill outputs.
    input wire logic DELINEATOR_PORT_IRQ,
    input wire logic PORT_SUMMARY_TX,
    input wire logic PORT_SUMMARY_RX,
    input wire logic REPEAT_LAST_CELL
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rd_ok;
    logic wr_ok;
    logic mapped;
    // Qualified strobes and decode of the implemented offsets.
    assign rd_ok = CPU_SEL && CPU_RD;
    assign wr_ok = CPU_SEL && CPU_WR;
    assign mapped = CPU_ADDR inside {8'h00, 8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e};
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // ********************
    // Register read checks.
    // ********************
    a_unmapped_reads_zero: assert property (
        rd_ok && !mapped |=> CPU_RDATA == 8'h00)
        else $error("Unmapped read returned data.");
    a_tx_flags_unused: assert property (
        rd_ok && CPU_ADDR == 8'h2c |=> CPU_RDATA[1:0] == 2'h0)
        else $error("Unused transmit flag bits set.");
    a_rx_bit_empty: assert property (
        rd_ok && CPU_ADDR == 8'h2d |=> !CPU_RDATA[4])
        else $error("Receive flag bit 4 set.");
    a_status_read_ctl: assert property (
        rd_ok && !wr_ok && CPU_ADDR == 8'h2e
        |=> !CPU_RDATA[1] && CPU_RDATA[0] == REPEAT_LAST_CELL)
        else $error("Status read disagrees with gap-fill control.");
    a_summary_upper_zero: assert property (
        rd_ok && CPU_ADDR == 8'h00 |=> CPU_RDATA[7:2] == 6'h00)
        else $error("Summary upper bits set.");
    a_rdata_holds: assert property (
        !rd_ok |=> $stable(CPU_RDATA))
        else $error("Read data changed without a read.");
    // ********************
    // Output relations.
    // ********************
    a_repeat_follows_wr: assert property (
        wr_ok && CPU_ADDR == 8'h2e
        |=> REPEAT_LAST_CELL == $past(CPU_WDATA[0]))
        else $error("Gap-fill control missed a write.");
    a_repeat_holds: assert property (
        !(wr_ok && CPU_ADDR == 8'h2e) |=> $stable(REPEAT_LAST_CELL))
        else $error("Gap-fill control changed without a write.");
    a_irq_needs_flag: assert property (
        DELINEATOR_PORT_IRQ |-> PORT_SUMMARY_TX || PORT_SUMMARY_RX)
        else $error("Interrupt raised with nothing pending.");
    // Main scenarios reached.
    c_irq_raised: cover property ($rose(DELINEATOR_PORT_IRQ));
    c_flags_read: cover property (
        rd_ok && CPU_ADDR == 8'h2c ##1 CPU_RDATA != 8'h00);
    c_repeat_on: cover property ($rose(REPEAT_LAST_CELL));
endmodule : acis_cell_irq_monitor

bind acis_cell_irq acis_cell_irq_monitor u_monitor (
    .CLK(CLK), .RST(RST), .CPU_SEL(CPU_SEL), .CPU_RD(CPU_RD),
    .CPU_WR(CPU_WR), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
    .CPU_RDATA(CPU_RDATA), .DELINEATOR_PORT_IRQ(DELINEATOR_PORT_IRQ),
    .PORT_SUMMARY_TX(PORT_SUMMARY_TX), .PORT_SUMMARY_RX(PORT_SUMMARY_RX),
    .REPEAT_LAST_CELL(REPEAT_LAST_CELL)
);

//--- verif/acis_cell_irq_tb.sv
module acis_cell_irq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [4:0] tx_ev = 5'h00;
    logic strobe = 1'b0;
    logic bound = 1'b0;
    logic soc_pin = 1'b0;
    logic [7:0] rx_lv = 8'h00;
    logic [7:0] rdata;
    logic irq, sum_tx, sum_rx, rep;
    logic [7:0] en;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int tbit [5] = '{7, 5, 4, 3, 2};
    // Clock of 100 ns period.
    initial begin
        forever #50 clk = ~clk;
    end
    // Block under test with every input driven by the bench.
    acis_cell_irq dut (
        .CLK(clk), .RST(rst), .CPU_SEL(sel), .CPU_RD(rd), .CPU_WR(wr),
        .CPU_ADDR(addr), .CPU_WDATA(wdata), .CPU_RDATA(rdata),
        .TX_PARITY_ERR(tx_ev[0]), .TX_FIFO_OVERFLOW(tx_ev[1]),
        .RX_FIFO_OVERFLOW(tx_ev[2]), .TX_CELL_SENT(tx_ev[3]),
        .TX_BUS_CONFLICT(tx_ev[4]), .TX_OCTET_STROBE(strobe),
        .TX_CELL_BOUNDARY(bound), .TX_CELL_START_IN(soc_pin),
        .RX_DELINEATION_LOSS(rx_lv[7]), .RX_HEC_DETECT(rx_lv[6]),
        .RX_HEC_CORRECT(rx_lv[5]), .RX_CELL_RX(rx_lv[3]),
        .RX_IDLE_RX(rx_lv[2]), .RX_UNMATCHED_CELL(rx_lv[1]),
        .RX_NONZERO_FLOW_CTL(rx_lv[0]), .DELINEATOR_PORT_IRQ(irq),
        .PORT_SUMMARY_TX(sum_tx), .PORT_SUMMARY_RX(sum_rx),
        .REPEAT_LAST_CELL(rep)
    );
    // ********************
    // Shared tasks.
    // ********************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    // Read cycle: strobe for one edge, data settles after the next.
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sel <= 1'b1;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        sel <= 1'b0;
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rc
    task automatic wrt(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sel <= 1'b1;
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        sel <= 1'b0;
        wr <= 1'b0;
        #1;
    endtask : wrt
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(input int k);
        @(posedge clk);
        tx_ev <= 5'(1 << k);
        @(posedge clk);
        tx_ev <= 5'h00;
    endtask : pulse
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // A run far beyond its expected length counts as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    // ********************
    // Test sequence.
    // ********************
    initial begin
        void'($urandom(32'h6d4977c5));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk({4'h0, irq, sum_tx, sum_rx, rep}, 8'h00);
        rc(8'h29, 8'hff);
        rc(8'h2c, 8'h00);
        rc(8'h2d, 8'h00);
        rc(8'h2e, 8'h00);
        rc(8'h55, 8'h00);
        $display("Reset test done");
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            tick(3);
            chk({6'h00, irq, sum_tx}, 8'h03);
            rc(8'h00, 8'h02);
            rc(8'h2c, 8'(1 << tbit[k]));
            pulse(k);
            rc(8'h2c, 8'h00);
            rc(8'h2e, 8'(1 << tbit[k]));
            rc(8'h2e, 8'h00);
            chk({6'h00, irq, sum_tx}, 8'h00);
        end
        wrt(8'h28, 8'h00);
        pulse(0);
        rc(8'h2c, 8'h00);
        rc(8'h2e, 8'h80);
        wrt(8'h28, 8'hfc);
        $display("Transmit event test done");
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            strobe <= 1'b1;
            bound <= c[0];
            soc_pin <= c[1];
            @(posedge clk);
            strobe <= 1'b0;
            bound <= 1'b0;
            soc_pin <= 1'b0;
            tick(4);
            rc(8'h2e, (c[0] ^ c[1]) ? 8'h40 : 8'h00);
            rc(8'h2c, (c[0] ^ c[1]) ? 8'h40 : 8'h00);
        end
        $display("Start-of-cell test done");
        for (int i = 0; i < 4; i++) begin
            en = (i == 0) ? 8'h00 : 8'($urandom);
            wrt(8'h29, en);
            rc(8'h29, en);
            @(posedge clk);
            rx_lv <= 8'hef;
            tick(3);
            chk({7'h00, irq}, {7'h00, |(en & 8'hef)});
            chk({7'h00, sum_rx}, {7'h00, |(en & 8'hef)});
            rc(8'h2d, en & 8'hef);
            rc(8'h2d, 8'h00);
            @(posedge clk);
            rx_lv <= 8'h00;
            tick(3);
            rc(8'h2d, en & 8'h80);
        end
        wrt(8'h29, 8'hff);
        @(posedge clk);
        rx_lv <= 8'h08;
        sel <= 1'b1;
        rd <= 1'b1;
        addr <= 8'h2d;
        @(posedge clk);
        sel <= 1'b0;
        rd <= 1'b0;
        rx_lv <= 8'h00;
        rc(8'h2d, 8'h08);
        $display("Receive event test done");
        wrt(8'h2e, 8'hff);
        chk({7'h00, rep}, 8'h01);
        rc(8'h2e, 8'h01);
        wrt(8'h2c, 8'hff);
        rc(8'h2c, 8'h00);
        wrt(8'h2d, 8'hff);
        rc(8'h2d, 8'h00);
        wrt(8'h00, 8'hff);
        rc(8'h00, 8'h00);
        wrt(8'h2e, 8'h00);
        chk({7'h00, rep}, 8'h00);
        $display("Register access test done");
        wrap_up();
    end
endmodule : acis_cell_irq_tb
